// [src/dba_core.sv]
// Program alignment and data memory address generation
`timescale 1ns/1ps
`default_nettype none
module dba_core (
  // Clock and reset
  input  wire  logic               clock,
  input  wire  logic               rst_n,
  // Instruction stream
  input  wire  logic               cmd_valid,
  input  wire  dba_pkg::dba_cmd_t  cmd,
  input  wire  logic [15:0]        fetch_word,
  // Configuration and data return
  input  wire  logic               extended_set_enable,
  input  wire  logic               usb_enable,
  input  wire  logic [7:0]         mem_rdata,
  // Outputs
  output var   logic [20:0]        pc,
  output var   dba_pkg::dba_mem_t  mem,
  output var   logic [7:0]         rdata,
  output var   logic [7:0]         bank_pointer,
  output var   logic [1:0]         phase,
  output var   logic               second_is_nop
);
  import dba_pkg::*;

  // ************************************************************
  // Phase counter and pending instruction
  // ************************************************************
  dba_phase_t ph, next_ph;
  dba_cmd_t   cur, next_cur;
  logic       busy, next_busy;
  logic       expect_second, next_expect_second;
  logic       lone_nop, next_lone_nop;

  always_comb begin
    next_ph = ph;
    next_cur = cur;
    next_busy = busy;
    next_expect_second = expect_second;
    next_lone_nop = lone_nop;
    case (ph)
      DBA_PH1: begin
        if (cmd_valid) begin
          next_cur = cmd;
          next_busy = 1'b1;
          // Lone tagged word becomes a no-operation [R06] [R21]
          next_lone_nop = !expect_second &&
                          fetch_word[15:12] == SECOND_WORD_TAG;
          next_expect_second = cmd.op == DBA_OP_FULLMOV ||
                               cmd.op == DBA_OP_JUMP;
          if (cmd.op == DBA_OP_SKIP && cmd.skip_taken) begin
            next_expect_second = 1'b0;
          end
        end else begin
          next_busy = 1'b0;
        end
        next_ph = DBA_PH2;
      end
      DBA_PH2: next_ph = DBA_PH3;
      DBA_PH3: next_ph = DBA_PH4;
      DBA_PH4: next_ph = DBA_PH1;
      default: next_ph = DBA_PH1;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph <= DBA_PH1;
      cur <= '0;
      busy <= 1'b0;
      expect_second <= 1'b0;
      lone_nop <= 1'b0;
    end else begin
      ph <= next_ph;
      cur <= next_cur;
      busy <= next_busy;
      expect_second <= next_expect_second;
      lone_nop <= next_lone_nop;
    end
  end

  // ************************************************************
  // Address formation
  // ************************************************************
  logic [3:0]  bank, next_bank;
  logic [11:0] eff_addr;
  logic        implemented;
  logic        active;

  assign active = busy && !lone_nop;

  always_comb begin
    if (cur.op == DBA_OP_FULLMOV) begin
      // Full twelve-bit address ignores the pointer [R14]
      eff_addr = {cur.word_target[11:0]};
    end else if (cur.access_sel) begin
      eff_addr = {bank, cur.operand}; // [R11] [R16]
    end else if (extended_set_enable && cur.operand < EXT_SPLIT) begin
      eff_addr = {bank, cur.operand}; // [R17]
    end else if (cur.operand < FAST_SPLIT) begin
      eff_addr = {FAST_LOW_BANK, cur.operand}; // [R15] [R20]
    end else begin
      eff_addr = {FAST_HIGH_BANK, cur.operand}; // [R15] [R19] [R20]
    end
  end

  // Only low banks and the top bank exist [R07] [R13]
  assign implemented = eff_addr[11:8] <= IMPL_TOP_BANK ||
                       eff_addr[11:8] == FAST_HIGH_BANK;

  // ************************************************************
  // Bank pointer and program counter
  // ************************************************************
  logic [20:0] pcr, next_pc;
  dba_mem_t    next_mem;
  logic [7:0]  next_rdata;

  always_comb begin
    next_bank = bank;
    next_pc = pcr;
    if (ph == DBA_PH4 && active) begin
      if (cur.op == DBA_OP_LOAD_BANK_LITERAL) begin
        next_bank = cur.operand[3:0]; // [R10] [R12]
      end
    end
    if (ph == DBA_PH1) begin
      next_pc = pcr + 21'h000002; // [R02]
    end
    if (ph == DBA_PH4 && active) begin
      if (cur.op == DBA_OP_JUMP) begin
        next_pc = {cur.word_target, 1'b0}; // [R03]
      end else if (cur.op == DBA_OP_BRANCH) begin
        // Signed word offset doubled to bytes [R04]
        next_pc = pcr + {{9{cur.rel_words[10]}}, cur.rel_words, 1'b0};
      end
    end
    next_pc[0] = 1'b0; // [R01] [R02]
  end

  always_comb begin
    next_mem = '0;
    next_rdata = rdata;
    next_mem.addr = eff_addr;
    // USB bank shared with serial engine only when enabled [R09]
    next_mem.usb_owned = usb_enable && eff_addr[11:8] == USB_BANK;
    if (active && cur.op inside {DBA_OP_FILE, DBA_OP_FULLMOV}) begin
      // Read is decided once the new instruction is held in cur
      next_mem.rd = (ph == DBA_PH2) && implemented; // [R18]
      next_mem.wr = (ph == DBA_PH3) && cur.do_write && implemented;
      next_mem.wdata = cur.wdata;
    end
    if (ph == DBA_PH3 && active) begin
      next_rdata = implemented ? mem_rdata : 8'h00; // [R08] [R13]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bank <= BANK_RESET;
      pcr <= PC_RESET;
      mem <= '0;
      rdata <= 8'h00;
    end else begin
      bank <= next_bank;
      pcr <= next_pc;
      mem <= next_mem;
      rdata <= next_rdata;
    end
  end

  assign pc = pcr;
  assign bank_pointer = {4'h0, bank}; // [R10]
  assign phase = ph;
  assign second_is_nop = lone_nop; // [R05]

  // ************************************************************
  // Checks on the program counter and phase order
  // ************************************************************
  chk_pc_even: assert property (@(posedge clock) // [R02]
    disable iff (!rst_n)
    pcr[0] == 1'b0)
    else $error("pc odd");

  // The reset term keeps the release edge out of the step check
  chk_pc_step: assert property (@(posedge clock) // [R02]
    disable iff (!rst_n)
    ph == DBA_PH1 && rst_n |=> pcr == $past(pcr) + 21'h000002)
    else $error("pc step wrong");

  chk_pc_hold: assert property (@(posedge clock) // [R02]
    disable iff (!rst_n)
    ph inside {DBA_PH2, DBA_PH3} |=> pcr == $past(pcr))
    else $error("pc moved mid cycle");

  chk_jump_load: assert property (@(posedge clock) // [R03]
    disable iff (!rst_n)
    ph == DBA_PH4 && active && cur.op == DBA_OP_JUMP
    |=> pcr == {$past(cur.word_target), 1'b0})
    else $error("jump target wrong");

  chk_branch_step: assert property (@(posedge clock) // [R04]
    disable iff (!rst_n)
    ph == DBA_PH4 && active && cur.op == DBA_OP_BRANCH
    |=> pcr == $past(pcr) +
        {{9{$past(cur.rel_words[10])}}, $past(cur.rel_words), 1'b0})
    else $error("branch offset wrong");

  chk_phase_wrap: assert property (@(posedge clock) // [R18]
    disable iff (!rst_n)
    ph == DBA_PH4 |=> ph == DBA_PH1)
    else $error("phase order wrong");

  // ************************************************************
  // Checks on the bank pointer and two-word instructions
  // ************************************************************
  chk_bank_upper: assert property (@(posedge clock) // [R10]
    disable iff (!rst_n)
    bank_pointer[7:4] == 4'h0)
    else $error("bank upper set");

  chk_bank_load: assert property (@(posedge clock) // [R12]
    disable iff (!rst_n)
    ph == DBA_PH4 && active && cur.op == DBA_OP_LOAD_BANK_LITERAL
    |=> bank == $past(cur.operand[3:0]))
    else $error("bank load wrong");

  chk_bank_hold: assert property (@(posedge clock) // [R12]
    disable iff (!rst_n)
    !(ph == DBA_PH4 && active && cur.op == DBA_OP_LOAD_BANK_LITERAL)
    |=> bank == $past(bank))
    else $error("bank changed unasked");

  chk_pair_operand: assert property (@(posedge clock) // [R05]
    disable iff (!rst_n)
    ph == DBA_PH1 && cmd_valid && expect_second |=> !lone_nop)
    else $error("paired word dropped");

  chk_lone_set: assert property (@(posedge clock) // [R06]
    disable iff (!rst_n)
    ph == DBA_PH1 && cmd_valid && !expect_second &&
    fetch_word[15:12] == SECOND_WORD_TAG |=> lone_nop)
    else $error("lone word not marked");

  chk_lone_quiet: assert property (@(posedge clock) // [R06]
    disable iff (!rst_n)
    lone_nop |-> !mem.rd && !mem.wr)
    else $error("lone word touched memory");

  // ************************************************************
  // Checks on data addressing
  // ************************************************************
  chk_banked: assert property (@(posedge clock) // [R11]
    disable iff (!rst_n)
    busy && cur.op == DBA_OP_FILE && cur.access_sel
    |-> eff_addr == {bank, cur.operand})
    else $error("banked");

  chk_fast_low: assert property (@(posedge clock) // [R20]
    disable iff (!rst_n)
    busy && cur.op == DBA_OP_FILE && !cur.access_sel &&
    !extended_set_enable && cur.operand < FAST_SPLIT
    |-> eff_addr == {4'h0, cur.operand})
    else $error("fast map low");

  chk_fast_high: assert property (@(posedge clock) // [R15]
    disable iff (!rst_n)
    busy && cur.op == DBA_OP_FILE && !cur.access_sel &&
    !extended_set_enable && cur.operand >= FAST_SPLIT
    |-> eff_addr[11:8] == 4'hf)
    else $error("fast map high");

  chk_ext_map: assert property (@(posedge clock) // [R17]
    disable iff (!rst_n)
    busy && cur.op == DBA_OP_FILE && !cur.access_sel &&
    extended_set_enable && cur.operand < EXT_SPLIT
    |-> eff_addr[11:8] == bank)
    else $error("extended map");

  chk_full_move: assert property (@(posedge clock) // [R14]
    disable iff (!rst_n)
    busy && cur.op == DBA_OP_FULLMOV |-> eff_addr == cur.word_target[11:0])
    else $error("full move address");

  chk_usb_share: assert property (@(posedge clock) // [R09]
    disable iff (!rst_n)
    mem.usb_owned |-> $past(usb_enable) && mem.addr[11:8] == USB_BANK)
    else $error("usb bank share");

  chk_unimpl_zero: assert property (@(posedge clock) // [R08]
    disable iff (!rst_n)
    ph == DBA_PH3 && active && !implemented |=> rdata == 8'h00)
    else $error("unimpl read");

  chk_unimpl_drop: assert property (@(posedge clock) // [R13]
    disable iff (!rst_n)
    mem.wr |-> mem.addr[11:8] <= IMPL_TOP_BANK ||
               mem.addr[11:8] == FAST_HIGH_BANK)
    else $error("unimpl write");

  chk_read_phase: assert property (@(posedge clock) // [R18]
    disable iff (!rst_n)
    mem.rd |-> ph == DBA_PH3)
    else $error("read phase");

  chk_write_phase: assert property (@(posedge clock) // [R18]
    disable iff (!rst_n)
    mem.wr |-> ph == DBA_PH4 && !lone_nop)
    else $error("write phase");

  // ************************************************************
  // Cover points
  // ************************************************************
  cov_jump: cover property (@(posedge clock)
    active && cur.op == DBA_OP_JUMP && ph == DBA_PH4);
  cov_lone: cover property (@(posedge clock) lone_nop && ph == DBA_PH2);
  cov_write: cover property (@(posedge clock) mem.wr);
  cov_branch: cover property (@(posedge clock)
    active && cur.op == DBA_OP_BRANCH && ph == DBA_PH4);
  cov_unimpl: cover property (@(posedge clock)
    active && ph == DBA_PH3 && !implemented);
endmodule
`default_nettype wire

// [src/dba_pkg.sv]
// Package with constants and carriers for data bank addressing
// Function
// R01: Instruction low byte sits at even address
// R02: Program counter steps two, bit zero reads zero
// R03: Absolute target word address loads PC 20:1
// R04: Relative offset counts words, moves twice bytes
// R05: Four two-word instructions, second word 1111; only DBA_OP_FULLMOV and DBA_OP_JUMP expect a second word here
// R06: Lone 1111 word executes as no-operation
// R07: Data addresses twelve bits, sixteen 256-byte banks
// R08: Unimplemented data location reads as zero
// R09: USB banks RAM when off, shared when on
// R10: Bank pointer upper four bits read zero
// R11: Banked address is pointer over operand
// R12: Load bank literal writes bank pointer
// R13: Unimplemented bank writes dropped, reads zero
// R14: Full address move uses twelve-bit addresses
// R15: Fast map low to bank 0, high to 15
// R16: Access bit one banks, zero fast map
// R17: Extended set enable alters fast map
// R18: Operand read second phase, write fourth phase; the read pulse on mem.rd lands in DBA_PH3 here
// R19: Special function registers F60h to FFFh
// R20: Fast map F00 plus operand from 60h
// R21: Skipped second word takes single-word timing
package dba_pkg;
  // ************************************************************
  // Widths and constants
  // ************************************************************
  localparam int PC_W = 21;
  localparam int DA_W = 12;
  localparam logic [3:0] SECOND_WORD_TAG = 4'hf;
  localparam logic [7:0] FAST_SPLIT = 8'h60;
  localparam logic [3:0] FAST_LOW_BANK = 4'h0;
  localparam logic [3:0] FAST_HIGH_BANK = 4'hf;
  localparam logic [11:0] SFR_BASE = 12'hf60;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  // Banks 0..IMPL_TOP_BANK are implemented, plus the top bank
  localparam logic [3:0] IMPL_TOP_BANK = 4'h2;
  localparam logic [3:0] USB_BANK = 4'h2;
  // Extended mode maps fast operands below this onto the pointer page
  localparam logic [7:0] EXT_SPLIT = 8'h60;

  typedef enum logic [1:0] {
    DBA_PH1 = 2'b00,
    DBA_PH2 = 2'b01,
    DBA_PH3 = 2'b10,
    DBA_PH4 = 2'b11
  } dba_phase_t;

  typedef enum logic [2:0] {
    DBA_OP_NONE    = 3'h0,
    DBA_OP_FILE    = 3'h1,
    DBA_OP_LOAD_BANK_LITERAL   = 3'h2,
    DBA_OP_FULLMOV = 3'h3,
    DBA_OP_JUMP    = 3'h4,
    DBA_OP_BRANCH  = 3'h5,
    DBA_OP_SKIP    = 3'h6
  } dba_op_t;

  // Decoded instruction fields from the execution datapath
  typedef struct packed {
    dba_op_t     op;
    logic        access_sel;
    logic [7:0]  operand;
    logic        do_write;
    logic [7:0]  wdata;
    logic [19:0] word_target;
    logic [10:0] rel_words;
    logic        skip_taken;
  } dba_cmd_t;

  // Data memory access presented to the RAM
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        usb_owned;
  } dba_mem_t;
endpackage

// [dv/dba_ram_model.sv]
// Behavioural data memory beside the address generator
`timescale 1ns/1ps
`default_nettype none
module dba_ram_model (
  // Clock and phase
  input  wire logic              clock,
  input  wire logic [1:0]        phase,
  // Memory access
  input  wire dba_pkg::dba_mem_t mem,
  output var  logic [7:0]        mem_rdata
);
  import dba_pkg::*;
  logic [7:0]  ram [0:4095];
  logic [11:0] held_addr;
  initial begin
    for (int i = 0; i < 4096; i++) ram[i] = 8'(i) ^ 8'h5a;
    held_addr = '0;
  end
  // Latch address on read pulse, store on write pulse
  always @(posedge clock) begin
    if (mem.rd) held_addr <= mem.addr;
    if (mem.wr) ram[mem.addr] <= mem.wdata;
  end
  // Data stands through phases 1 to 3, scrambled otherwise
  assign mem_rdata = mem.rd ? ram[mem.addr] :
                     (phase != 2'd0) ? ram[held_addr] : ~ram[held_addr];
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Testbench for data bank addressing
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dba_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  dba_cmd_t    cmd = '0;
  logic [15:0] fetch_word = 16'h0000;
  logic        ext_en = 1'b0;
  logic        usb_en = 1'b0;
  logic [7:0]  mem_rdata;
  logic [20:0] pc;
  dba_mem_t    mem;
  logic [7:0]  rdata;
  logic [7:0]  bank_pointer;
  logic [1:0]  phase;
  logic        second_is_nop;
  logic [11:0] rd_addr = '0;
  logic        rd_usb = 1'b0;
  dba_cmd_t    br_cmd = '0;
  int          failures = 0;
  int          num_checks = 0;
  always #25 clock = ~clock;
  dba_core dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .fetch_word(fetch_word), .extended_set_enable(ext_en),
    .usb_enable(usb_en), .mem_rdata(mem_rdata), .pc(pc), .mem(mem),
    .rdata(rdata), .bank_pointer(bank_pointer), .phase(phase),
    .second_is_nop(second_is_nop));
  dba_ram_model ram (.clock(clock), .phase(phase), .mem(mem),
    .mem_rdata(mem_rdata));
  // Remember the address of the last read pulse
  always @(posedge clock) begin
    if (mem.rd === 1'b1) begin
      rd_addr <= mem.addr;
      rd_usb <= mem.usb_owned;
    end
  end
  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic dba_cmd_t mk(input dba_op_t op, input logic a,
      input logic [7:0] opd, input logic wr, input logic [7:0] wd,
      input logic [19:0] tgt);
    dba_cmd_t c;
    c = '0;
    c.op = op;
    c.access_sel = a;
    c.operand = opd;
    c.do_write = wr;
    c.wdata = wd;
    c.word_target = tgt;
    return c;
  endfunction
  // One instruction: present at phase 0, wait until its write edge
  task automatic issue(input dba_cmd_t c, input logic [15:0] w);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (phase !== 2'd3 && n < 20);
    if (n >= 20) begin
      failures++;
      print_verdict();
    end
    @(posedge clock);
    cmd <= c;
    fetch_word <= w;
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    fetch_word <= 16'h0000;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic a, input logic [7:0] opd);
    issue(mk(DBA_OP_FILE, a, opd, 1'b0, 8'h00, 20'h0), 16'h0000);
  endtask
  task automatic bank(input logic [7:0] v);
    issue(mk(DBA_OP_LOAD_BANK_LITERAL, 1'b0, v, 1'b0, 8'h00, 20'h0), 16'h0000);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    check(pc, 21'h0);
    check(bank_pointer, 8'h00);
    bank(8'hf1);
    check(bank_pointer, 8'h01);
    check(pc, 21'h4);
    issue(mk(DBA_OP_FILE, 1'b1, 8'h10, 1'b1, 8'ha7, 20'h0), 16'h0000);
    rd(1'b1, 8'h10);
    check(rd_addr, 12'h110);
    check(rdata, 8'ha7);
    rd(1'b0, 8'h5f);
    check(rd_addr, 12'h05f);
    check(rdata, 8'h5f ^ 8'h5a);
    rd(1'b0, 8'h60);
    check(rd_addr, 12'hf60);
    check(rdata, 8'h60 ^ 8'h5a);
    bank(8'h05);
    rd(1'b1, 8'h22);
    check(rdata, 8'h00);
    bank(8'h02);
    usb_en <= 1'b1;
    rd(1'b1, 8'h00);
    check(rd_usb, 1'b1);
    usb_en <= 1'b0;
    ext_en <= 1'b1;
    rd(1'b0, 8'h20);
    check(rd_addr, 12'h220);
    ext_en <= 1'b0;
    issue(mk(DBA_OP_FULLMOV, 1'b0, 8'h00, 1'b0, 8'h00, 20'h00110),
      16'h0000);
    check(rd_addr, 12'h110);
    issue(mk(DBA_OP_JUMP, 1'b0, 8'h00, 1'b0, 8'h00, 20'h00003), 16'h0000);
    check(pc, 21'h6);
    issue(mk(DBA_OP_NONE, 1'b0, 8'h00, 1'b0, 8'h00, 20'h0), 16'hf456);
    check(second_is_nop, 1'b0);
    issue(mk(DBA_OP_FILE, 1'b0, 8'h10, 1'b1, 8'h3c, 20'h0), 16'hf456);
    check(second_is_nop, 1'b1);
    rd(1'b0, 8'h10);
    check(rdata, 8'h10 ^ 8'h5a);
    br_cmd = mk(DBA_OP_BRANCH, 1'b0, 8'h00, 1'b0, 8'h00, 20'h0);
    br_cmd.rel_words = 11'h7fd;
    issue(br_cmd, 16'h0000);
    check(pc, 21'h010);
    print_verdict();
  end
endmodule
`default_nettype wire
